// ### design/system_reset_sequencer.sv
// Reset sequencer: gathers reset sources, holds the core, releases it at the reset vector.
// Assumes analog comparators, watchdog and reset pin are asynchronous to clk,
// option inputs are static factory settings, and software uses classic Wishbone.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "srs_map.svh"

// Behaviour
// - Accept power-on, watchdog, brown-out and pin resets; pin only when enabled.
// - During any reset hold registers initialised, halt execution, clear the PC.
// - After the sequence completes, fetch starts at program address zero.
// - Cause sits in flag bits 7:6; 00 is watchdog, 01 never produced.
// - Power-on or low-voltage reset writes cause 10.
// - External pin reset writes cause 11.
// - Order: supply stable, pin check, register init, oscillator warm-up, run.
// - With the pin enabled and low, stay in reset until it goes high.
// - Watchdog overflow resets, then init and warm-up before running again.
// - Execution stays halted until the oscillator warm-up has finished.
// - The 2.0 V detector resets under every option.
// - The 2.4 V detector flags under middle, resets under high, unused under low.
// - Bit 4 reads one at or below 2.4 V, only under the middle option.
// - Bit 5 reads one at or below 3.6 V, only under the high option.
// - Any low-voltage reset clears both supply indicator flags.
// - The pin is active low, option-enabled, acting at power-up and while running.
module system_reset_sequencer #(
	parameter int WARM_CYCLES = `SRS_WARM_CYCLES
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      supplyStable,
	input  wire logic                      below20,
	input  wire logic                      below24,
	input  wire logic                      below36,
	input  wire logic                      wdtOverflow,
	input  wire logic                      extResetPin_n,
	input  wire logic                      oscStable,
	input  wire logic                      extPinEnable,
	input  wire srs_pkg::srs_option_t      undervoltOption,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [`SRS_ADR_W-1:0]     wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	output logic                           coreReset,
	output logic                           regInit,
	output logic                           fetchEnable,
	output logic      [`SRS_PC_W-1:0]      fetchAddress,
	output logic                           irq
);
	srs_pkg::srs_sense_t raw;
	srs_pkg::srs_sense_t sense;
	srs_pkg::srs_state_t state;
	srs_pkg::srs_state_t next_state;

	logic                  warmDone;
	logic                  lvdReset;
	logic                  pinReset;
	logic                  wdtReset;
	logic                  anySource;
	logic [1:0]            pendingCause;
	logic [1:0]            causeBits;
	logic                  midFlag;
	logic                  highFlag;
	logic                  midFlagPrev;
	logic                  highFlagPrev;
	logic [`SRS_IRQ_W-1:0] irqStatus;
	logic [`SRS_IRQ_W-1:0] irqMask;
	logic [`SRS_IRQ_W-1:0] irqEvents;
	logic                  busReq;
	logic                  busWrite;
	logic [7:0]            readByte;

	function automatic logic hitIndex(input logic [`SRS_ADR_W-1:0] adr,
		input logic [`SRS_IDX_W-1:0] idx);
		hitIndex = (adr[`SRS_ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
	endfunction

	// One driver for the whole bundle; the order follows srs_sense_t, first member on top.
	assign raw = {below20, below24, below36, wdtOverflow, extResetPin_n, supplyStable, oscStable};

	// The pin idles high and the supply idles bad, so nothing runs before the chain fills.
	srs_sync #(
		.W       ($bits(srs_pkg::srs_sense_t)),
		.RST_VAL (`SRS_SYNC_IDLE)
	) u_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.async  (raw),
		.synced (sense)
	);

	// The 2.4 V level resets only under the high option; 2.0 V always does.
	assign lvdReset = !sense.supplyStable || sense.below20 ||
		(sense.below24 && undervoltOption == srs_pkg::SRS_OPT_HIGH);
	assign pinReset = extPinEnable && !sense.extPin_n;
	assign wdtReset = sense.wdtOverflow;
	assign anySource = lvdReset || pinReset || wdtReset;

	srs_warmup #(
		.CYCLES (WARM_CYCLES)
	) u_warm (
		.clk       (clk),
		.rst_n     (rst_n),
		.restart   (state != srs_pkg::SRS_WARM),
		.oscStable (sense.oscStable),
		.done      (warmDone)
	);

	always_comb begin
		next_state = state;
		case (state)
			srs_pkg::SRS_POWER: begin
				if (!lvdReset) begin
					next_state = srs_pkg::SRS_EXTPIN;
				end
			end
			srs_pkg::SRS_EXTPIN: begin
				if (lvdReset) begin
					next_state = srs_pkg::SRS_POWER;
				end else if (!pinReset && !wdtReset) begin
					next_state = srs_pkg::SRS_INIT;
				end
			end
			srs_pkg::SRS_INIT: begin
				next_state = anySource ? srs_pkg::SRS_POWER : srs_pkg::SRS_WARM;
			end
			srs_pkg::SRS_WARM: begin
				if (anySource) begin
					next_state = srs_pkg::SRS_POWER;
				end else if (warmDone) begin
					next_state = srs_pkg::SRS_RUN;
				end
			end
			srs_pkg::SRS_RUN: begin
				if (anySource) begin
					next_state = srs_pkg::SRS_POWER;
				end
			end
			default: begin
				next_state = srs_pkg::SRS_POWER;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= srs_pkg::SRS_POWER;
		end else begin
			state <= next_state;
		end
	end

	// Core control comes from flops so the core never sees a decode glitch.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coreReset    <= 1'b1;
			fetchEnable  <= 1'b0;
			regInit      <= 1'b0;
			fetchAddress <= `SRS_RESET_VECTOR;
		end else begin
			coreReset   <= (next_state != srs_pkg::SRS_RUN);
			fetchEnable <= (next_state == srs_pkg::SRS_RUN);
			regInit     <= (next_state == srs_pkg::SRS_INIT);
			if (next_state != srs_pkg::SRS_RUN) begin
				fetchAddress <= `SRS_RESET_VECTOR;
			end
		end
	end

	// The pending cause only climbs in priority while reset lasts, so a watchdog
	// overflow during a brown-out still reports the brown-out.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pendingCause <= `SRS_CAUSE_POR;
		end else if (lvdReset) begin
			pendingCause <= `SRS_CAUSE_POR;
		end else if (pinReset && pendingCause != `SRS_CAUSE_POR) begin
			pendingCause <= `SRS_CAUSE_EXT;
		end else if (state == srs_pkg::SRS_RUN) begin
			pendingCause <= `SRS_CAUSE_WDT;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			causeBits <= `SRS_CAUSE_POR;
		end else if (state == srs_pkg::SRS_WARM && next_state == srs_pkg::SRS_RUN) begin
			causeBits <= pendingCause;
		end else if (busWrite && hitIndex(wb_adr_i, `SRS_FLAGS_IDX) && wb_sel_i[0]) begin
			causeBits <= wb_dat_i[`SRS_CAUSE_HI:`SRS_CAUSE_LO];
		end
	end

	// Flags follow the comparators only while running; any reset clears them.
	always_ff @(posedge clk) begin
		if (!rst_n || state != srs_pkg::SRS_RUN) begin
			midFlag  <= 1'b0;
			highFlag <= 1'b0;
		end else begin
			midFlag  <= sense.below24 && undervoltOption == srs_pkg::SRS_OPT_MIDDLE;
			highFlag <= sense.below36 && undervoltOption == srs_pkg::SRS_OPT_HIGH;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			midFlagPrev  <= 1'b0;
			highFlagPrev <= 1'b0;
		end else begin
			midFlagPrev  <= midFlag;
			highFlagPrev <= highFlag;
		end
	end

	always_comb begin
		irqEvents                = '0;
		irqEvents[`SRS_IRQ_MID]  = midFlag && !midFlagPrev;
		irqEvents[`SRS_IRQ_HIGH] = highFlag && !highFlagPrev;
		irqEvents[`SRS_IRQ_DONE] = (next_state == srs_pkg::SRS_RUN) && !fetchEnable;
	end

	assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign busWrite = busReq && wb_we_i;

	// A new event beats a write-one-to-clear in the same cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqStatus <= '0;
		end else if (busWrite && hitIndex(wb_adr_i, `SRS_IRQ_STAT_IDX) && wb_sel_i[0]) begin
			irqStatus <= (irqStatus & ~wb_dat_i[`SRS_IRQ_W-1:0]) | irqEvents;
		end else begin
			irqStatus <= irqStatus | irqEvents;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqMask <= '0;
		end else if (busWrite && hitIndex(wb_adr_i, `SRS_IRQ_MASK_IDX) && wb_sel_i[0]) begin
			irqMask <= wb_dat_i[`SRS_IRQ_W-1:0];
		end
	end

	assign irq = |(irqStatus & irqMask);

	always_comb begin
		readByte = 8'h00;
		if (hitIndex(wb_adr_i, `SRS_FLAGS_IDX)) begin
			readByte[`SRS_CAUSE_HI:`SRS_CAUSE_LO] = causeBits;
			readByte[`SRS_HIGH_BIT]               = highFlag;
			readByte[`SRS_MID_BIT]                = midFlag;
		end else if (hitIndex(wb_adr_i, `SRS_IRQ_STAT_IDX)) begin
			readByte[`SRS_IRQ_W-1:0] = irqStatus;
		end else if (hitIndex(wb_adr_i, `SRS_IRQ_MASK_IDX)) begin
			readByte[`SRS_IRQ_W-1:0] = irqMask;
		end
	end

	// Every access is acknowledged after one wait cycle; unmapped reads return zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= (busReq && !wb_we_i) ? {24'h000000, readByte} : 32'h00000000;
		end
	end

	a_reset_halts: assert property (@(posedge clk) disable iff (!rst_n)
		(state == srs_pkg::SRS_RUN && anySource) |=> (coreReset && !fetchEnable))
		else $error("core not halted after a reset source");

	a_vector_zero: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(fetchEnable) |-> (fetchAddress == `SRS_RESET_VECTOR))
		else $error("fetch did not start at the reset vector");

	a_cause_legal: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(fetchEnable) |-> (causeBits != `SRS_CAUSE_RSVD))
		else $error("reserved reset cause produced");

	a_cause_release: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(fetchEnable) |-> (causeBits == $past(pendingCause)))
		else $error("cause bits not written at release");

	a_lvd_cause: assert property (@(posedge clk) disable iff (!rst_n)
		lvdReset |=> (pendingCause == `SRS_CAUSE_POR))
		else $error("low-voltage reset not recorded as 10");

	a_pin_holds: assert property (@(posedge clk) disable iff (!rst_n)
		pinReset |=> (!fetchEnable [*2]))
		else $error("ran while the reset pin was low");

	a_warm_first: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(fetchEnable) |-> ($past(warmDone) && $past(state) == srs_pkg::SRS_WARM))
		else $error("released before oscillator warm-up");

	a_init_order: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(regInit) |-> ($past(state) == srs_pkg::SRS_EXTPIN))
		else $error("register init out of order");

	a_flag_option: assert property (@(posedge clk) disable iff (!rst_n)
		(undervoltOption != srs_pkg::SRS_OPT_MIDDLE) |-> ##1 !midFlag)
		else $error("2.4 V flag set outside the middle option");

	a_high_option: assert property (@(posedge clk) disable iff (!rst_n)
		(undervoltOption != srs_pkg::SRS_OPT_HIGH) |-> ##1 !highFlag)
		else $error("3.6 V flag set outside the high option");

	a_flags_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(state == srs_pkg::SRS_RUN && lvdReset) |=> ##1 (!midFlag && !highFlag))
		else $error("indicator flags not cleared by low-voltage reset");

	a_pin_cause: assert property (@(posedge clk) disable iff (!rst_n)
		(pinReset && !lvdReset && pendingCause != `SRS_CAUSE_POR) |=> (pendingCause == `SRS_CAUSE_EXT))
		else $error("pin reset not recorded as 11");

	a_wdt_cause: assert property (@(posedge clk) disable iff (!rst_n)
		(state == srs_pkg::SRS_RUN && !pinReset && !lvdReset) |=> (pendingCause == `SRS_CAUSE_WDT))
		else $error("running cause not reset to watchdog code");

	a_init_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		regInit |=> !regInit)
		else $error("register init longer than one cycle");

	a_pc_cleared: assert property (@(posedge clk) disable iff (!rst_n)
		coreReset |-> (fetchAddress == `SRS_RESET_VECTOR))
		else $error("program counter not cleared during reset");

	a_pin_resets: assert property (@(posedge clk) disable iff (!rst_n)
		(extPinEnable && !sense.extPin_n && state == srs_pkg::SRS_RUN) |=> coreReset)
		else $error("enabled reset pin ignored while running");

	a_wdt_resets: assert property (@(posedge clk) disable iff (!rst_n)
		(sense.wdtOverflow && state == srs_pkg::SRS_RUN) |=> coreReset)
		else $error("watchdog overflow ignored while running");

	a_low_resets: assert property (@(posedge clk) disable iff (!rst_n)
		(sense.below20 && state == srs_pkg::SRS_RUN) |=> coreReset)
		else $error("2.0 V detector ignored while running");

	a_mid_no_reset: assert property (@(posedge clk) disable iff (!rst_n)
		(sense.below24 && undervoltOption == srs_pkg::SRS_OPT_MIDDLE && !sense.below20 &&
		sense.supplyStable && !pinReset && !wdtReset && state == srs_pkg::SRS_RUN) |=> fetchEnable)
		else $error("2.4 V level reset under the middle option");

	a_warm_halts: assert property (@(posedge clk) disable iff (!rst_n)
		(state == srs_pkg::SRS_WARM && !warmDone) |=> !fetchEnable)
		else $error("execution released during warm-up");
endmodule

// ### common/srs_map.svh
// Register indices, field positions, codes and timing figures of the reset sequencer.
// Assumes inclusion by bare name from design files that use these names.
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH

`define SRS_ADR_W        12
`define SRS_IDX_W        10
`define SRS_FLAGS_IDX    10'h086
`define SRS_IRQ_STAT_IDX 10'h088
`define SRS_IRQ_MASK_IDX 10'h089

`define SRS_CAUSE_HI     7
`define SRS_CAUSE_LO     6
`define SRS_HIGH_BIT     5
`define SRS_MID_BIT      4

`define SRS_CAUSE_WDT    2'h0
`define SRS_CAUSE_RSVD   2'h1
`define SRS_CAUSE_POR    2'h2
`define SRS_CAUSE_EXT    2'h3

`define SRS_IRQ_W        3
`define SRS_IRQ_MID      0
`define SRS_IRQ_HIGH     1
`define SRS_IRQ_DONE     2

`define SRS_PC_W         10
`define SRS_RESET_VECTOR 10'h000

// Synchroniser contents under reset: pin released, supply not yet good, no overflow.
`define SRS_SYNC_IDLE    7'h04

`define SRS_WARM_NS      1000
`define SRS_CLK_MHZ      200
`define SRS_WARM_CYCLES  ((`SRS_WARM_NS * `SRS_CLK_MHZ + 999) / 1000)

`endif

// ### common/srs_pkg.sv
// Types shared by the reset sequencer modules.
// Assumes nothing of its surroundings.
package srs_pkg;

	typedef enum logic [2:0] {
		SRS_POWER  = 3'h0,
		SRS_EXTPIN = 3'h1,
		SRS_INIT   = 3'h2,
		SRS_WARM   = 3'h3,
		SRS_RUN    = 3'h4
	} srs_state_t;

	typedef enum logic [1:0] {
		SRS_OPT_LOW    = 2'h0,
		SRS_OPT_MIDDLE = 2'h1,
		SRS_OPT_HIGH   = 2'h2
	} srs_option_t;

	typedef struct packed {
		logic below20;
		logic below24;
		logic below36;
		logic wdtOverflow;
		logic extPin_n;
		logic supplyStable;
		logic oscStable;
	} srs_sense_t;

endpackage

// ### design/srs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a slow level; pulses shorter than two clocks may be lost.
`timescale 1ns/1ps
module srs_sync #(
	parameter int           W       = 7,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async,
	output logic      [W-1:0] synced
);
	logic [W-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					stage1[i] <= RST_VAL[i];
					synced[i] <= RST_VAL[i];
				end else begin
					stage1[i] <= async[i];
					synced[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule

// ### design/srs_warmup.sv
// Oscillator warm-up timer: counts stable oscillator cycles after a restart.
// Assumes oscStable is already synchronised to clk.
`timescale 1ns/1ps
module srs_warmup #(
	parameter int CYCLES = 200
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic restart,
	input  wire logic oscStable,
	output logic      done
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);

	logic [CW-1:0] count;

	// An unstable oscillator starts the count again, so done means a clean run.
	always_ff @(posedge clk) begin
		if (!rst_n || restart || !oscStable) begin
			count <= '0;
		end else if (count != LAST) begin
			count <= count + CW'(1);
		end
	end

	assign done = (count == LAST);
endmodule

// ### testbench/srs_env_model.sv
// Behavioural model of the supply detectors, watchdog overflow and reset pin.
// Assumes the bench changes its controls by non-blocking assignment at clk.
`timescale 1ns/1ps
module srs_env_model (
	input  wire logic         clk,
	input  wire logic [15:0]  vddMv,
	input  wire logic         wdtFire,
	input  wire logic         pinLow,
	input  wire logic         oscOn,
	output srs_pkg::srs_sense_t sense
);
	logic [1:0] wdtHold = 2'h0;

	// Overflow only on command, so software never clears it from two places.
	// It is stretched to three clocks so the two-flop synchroniser cannot miss it.
	always_ff @(posedge clk) begin
		if (wdtFire)
			wdtHold <= 2'h3;
		else if (wdtHold != 2'h0)
			wdtHold <= wdtHold - 2'h1;
	end

	assign sense.below20 = vddMv < 16'h07D0;
	assign sense.below24 = vddMv <= 16'h0960;
	assign sense.below36 = vddMv <= 16'h0E10;
	assign sense.wdtOverflow = wdtHold != 2'h0;
	assign sense.extPin_n = !pinLow;
	assign sense.supplyStable = vddMv >= 16'h07D0;
	assign sense.oscStable = oscOn;
endmodule

// ### testbench/system_reset_sequencer_tb.sv
// Self-checking bench: detector option table, then hand-written reset cases.
// Assumes WARM_CYCLES of 8 and the environment model for all analog sources.
`timescale 1ns/1ps
module system_reset_sequencer_tb;
	typedef struct packed {
		srs_pkg::srs_option_t opt;
		logic [15:0]          mv;
		logic                 run;
		logic [7:0]           flags;
	} srs_row_t;
	localparam logic [11:0] A_FLG = 12'h218;
	localparam logic [11:0] A_STA = 12'h220;
	localparam logic [11:0] A_MSK = 12'h224;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 wbCyc = 1'b0;
	logic                 wbStb = 1'b0;
	logic                 wbWe = 1'b0;
	logic [11:0]          wbAdr = 12'h000;
	logic [31:0]          wbDatW = 32'h0;
	logic [31:0]          wbDatR;
	logic                 wbAck, coreReset, regInit, fetchEnable, irq, ok;
	logic [9:0]           fetchAddress;
	logic [15:0]          vddMv = 16'h0CE4;
	logic                 wdtFire = 1'b0, pinLow = 1'b0, oscOn = 1'b1, pinEnable = 1'b0;
	srs_pkg::srs_option_t opt = srs_pkg::SRS_OPT_LOW;
	srs_pkg::srs_sense_t  sense;
	logic [7:0]           q;
	int                   bad_count = 0, n_checks = 0, initCnt = 0, base;
	srs_row_t rows [7] = '{
		'{srs_pkg::SRS_OPT_LOW, 16'h0960, 1'b1, 8'h80},
		'{srs_pkg::SRS_OPT_MIDDLE, 16'h0960, 1'b1, 8'h90},
		'{srs_pkg::SRS_OPT_MIDDLE, 16'h0961, 1'b1, 8'h80},
		'{srs_pkg::SRS_OPT_HIGH, 16'h0E10, 1'b1, 8'hA0},
		'{srs_pkg::SRS_OPT_HIGH, 16'h0960, 1'b0, 8'h80},
		'{srs_pkg::SRS_OPT_MIDDLE, 16'h07CF, 1'b0, 8'h80},
		'{srs_pkg::SRS_OPT_LOW, 16'h0E11, 1'b1, 8'h80}};

	srs_env_model i_srs_env_model (.clk(clk), .vddMv(vddMv), .wdtFire(wdtFire),
		.pinLow(pinLow), .oscOn(oscOn), .sense(sense));

	system_reset_sequencer #(.WARM_CYCLES(8)) i_system_reset_sequencer (
		.clk(clk), .rst_n(rst_n), .supplyStable(sense.supplyStable),
		.below20(sense.below20), .below24(sense.below24), .below36(sense.below36),
		.wdtOverflow(sense.wdtOverflow), .extResetPin_n(sense.extPin_n),
		.oscStable(sense.oscStable), .extPinEnable(pinEnable), .undervoltOption(opt),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(4'h1), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
		.coreReset(coreReset), .regInit(regInit), .fetchEnable(fetchEnable),
		.fetchAddress(fetchAddress), .irq(irq));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// Sampled at the edge, before the design's own updates land.
	always @(posedge clk) begin
		if (regInit === 1'b1)
			initCnt <= initCnt + 1;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wb(input logic [11:0] a, input logic w, input logic [7:0] d);
		int n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatW <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		chk(wbAck, 1'b1);
		q = wbDatR[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic doReset();
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk(coreReset, 1'b1);
		chk(fetchEnable, 1'b0);
		chk(irq, 1'b0);
		rst_n <= 1'b1;
	endtask

	task automatic waitRun(input int lim);
		ok = 1'b0;
		for (int i = 0; i < lim && ok !== 1'b1; i++) begin
			@(posedge clk);
			if (fetchEnable === 1'b1)
				ok = 1'b1;
			else
				chk(fetchAddress, 16'h0);
		end
	endtask

	initial begin
		#50000;
		bad_count++;
		print_verdict();
	end

	initial begin
		doReset();
		wb(A_MSK, 1'b0, 8'h00);
		chk(q, 16'h0);
		for (int r = 0; r < 7; r++) begin
			opt <= rows[r].opt;
			vddMv <= rows[r].mv;
			doReset();
			waitRun(40);
			chk(ok, rows[r].run);
			wb(A_FLG, 1'b0, 8'h00);
			chk(q, rows[r].flags);
		end
		$display("test option table done");
		base = initCnt;
		wdtFire <= 1'b1;
		@(posedge clk);
		wdtFire <= 1'b0;
		repeat (6) @(posedge clk);
		chk(coreReset, 1'b1);
		waitRun(60);
		chk(ok, 1'b1);
		chk(fetchAddress, 16'h0);
		chk(16'(initCnt - base), 16'h1);
		wb(A_FLG, 1'b0, 8'h00);
		chk(q, 16'h00);
		$display("test watchdog done");
		pinLow <= 1'b1;
		repeat (20) @(posedge clk);
		chk(fetchEnable, 1'b1);
		pinEnable <= 1'b1;
		base = initCnt;
		doReset();
		waitRun(40);
		chk(ok, 1'b0);
		chk(16'(initCnt - base), 16'h0);
		pinLow <= 1'b0;
		waitRun(60);
		chk(ok, 1'b1);
		wb(A_FLG, 1'b0, 8'h00);
		chk(q, 16'h80);
		pinLow <= 1'b1;
		repeat (6) @(posedge clk);
		chk(coreReset, 1'b1);
		pinLow <= 1'b0;
		waitRun(60);
		chk(ok, 1'b1);
		wb(A_FLG, 1'b0, 8'h00);
		chk(q, 16'hC0);
		$display("test reset pin done");
		opt <= srs_pkg::SRS_OPT_MIDDLE;
		vddMv <= 16'h0CE4;
		doReset();
		waitRun(60);
		wb(A_MSK, 1'b1, 8'h05);
		wb(A_STA, 1'b1, 8'h07);
		chk(irq, 1'b0);
		vddMv <= 16'h0960;
		repeat (6) @(posedge clk);
		chk(irq, 1'b1);
		wb(A_STA, 1'b0, 8'h00);
		chk(q, 16'h01);
		wb(A_STA, 1'b1, 8'h01);
		chk(irq, 1'b0);
		vddMv <= 16'h07CF;
		repeat (6) @(posedge clk);
		chk(coreReset, 1'b1);
		wb(A_FLG, 1'b0, 8'h00);
		chk(q & 8'h30, 16'h0);
		vddMv <= 16'h0CE4;
		waitRun(60);
		wb(A_FLG, 1'b0, 8'h00);
		chk(q, 16'h80);
		chk(irq, 1'b1);
		wb(12'h3FC, 1'b0, 8'h00);
		chk(q, 16'h0);
		$display("test brown-out and interrupt done");
		oscOn <= 1'b0;
		doReset();
		waitRun(40);
		chk(ok, 1'b0);
		oscOn <= 1'b1;
		waitRun(60);
		chk(ok, 1'b1);
		$display("test oscillator done");
		print_verdict();
	end
endmodule
